// ---- rws_consts.svh ----
`ifndef RWS_CONSTS_SVH
`define RWS_CONSTS_SVH
// ****************************************
// Register map (APB byte addresses)
// ****************************************
`define RWS_ADDR_CTRL 12'h000
`define RWS_ADDR_STATUS 12'h004
`define RWS_ADDR_SOURCE 12'h008
`define RWS_ADDR_VECTOR 12'h00C
`define RWS_ADDR_WDOG 12'h010
// Control register fields
`define RWS_CTRL_SHORTREC 0
`define RWS_CTRL_OSCSTOP 1
`define RWS_CTRL_WDOGEN 2
`define RWS_CTRL_EMUL 3
`define RWS_CTRL_WAITREQ 4
`define RWS_CTRL_STOPREQ 5
`define RWS_CTRL_RESET 8'h00
// Reset source flag positions
`define RWS_SRC_LVR 1
`define RWS_SRC_ILAD 2
`define RWS_SRC_ILOP 3
`define RWS_SRC_WDOG 4
`define RWS_SRC_PIN 6
`define RWS_SRC_POR 7
`define RWS_SRC_RESET 8'h80
// ****************************************
// Timing counts in crystal clock cycles
// ****************************************
`define RWS_STAB_CYC 4096
`define RWS_SHORT_CYC 32
`define RWS_PIN_CYC 32
`define RWS_CORE_CYC 32
`define RWS_CORE_FROM_STAB 64
`define RWS_XTAL_DIV 4
`define RWS_WDOG_CYC 262144
// ****************************************
// Vector addresses (high byte of pair)
// ****************************************
`define RWS_VEC_RESET 16'hFFFE
`define RWS_VEC_SWI 16'hFFFC
`define RWS_VEC_IRQ 16'hFFFA
`define RWS_VEC_CLKGEN 16'hFFF8
`define RWS_VEC_T1CH0 16'hFFF6
`define RWS_VEC_T1CH1 16'hFFF4
`define RWS_VEC_T1OVF 16'hFFF2
`define RWS_VEC_T2CH0 16'hFFF0
`define RWS_VEC_T2CH1 16'hFFEE
`define RWS_VEC_T2OVF 16'hFFEC
`define RWS_VEC_SPIRX 16'hFFEA
`define RWS_VEC_SPITX 16'hFFE8
`define RWS_VEC_SCIERR 16'hFFE6
`define RWS_VEC_SCIRX 16'hFFE4
`define RWS_VEC_SCITX 16'hFFE2
`define RWS_VEC_KEYPAD 16'hFFE0
`define RWS_VEC_ADC 16'hFFDE
`define RWS_VEC_TBASE 16'hFFDC
`define RWS_VEC_CANWAKE 16'hFFDA
`define RWS_VEC_CANERR 16'hFFD8
`define RWS_VEC_CANRX 16'hFFD6
`define RWS_VEC_CANTX 16'hFFD4
`endif

// ---- rws_pkg.sv ----
package rws_pkg;
    // Power mode of the core
    typedef enum logic [1:0] {RWS_RUN, RWS_WAIT, RWS_STOP} rws_mode_e;
    // Reset sequence phase
    typedef enum logic [2:0] {RWS_IDLE, RWS_STAB, RWS_PINLOW, RWS_HOLD,
        RWS_RECOVER} rws_phase_e;
endpackage

// ---- rws_delay_counter.sv ----
`timescale 1ns/1ps
// Loadable down counter; done pulses when it reaches zero
module rws_delay_counter #(
    parameter int WIDTH = 13
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic busy,
    output logic done
);
    // ****************************************
    // Counter
    // ****************************************
    logic [WIDTH-1:0] count_reg; // Cycles left
    initial begin
        if (WIDTH < 2) $error("rws_delay_counter: WIDTH too small");
    end
    // Load wins over counting
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= loadValue;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    // Done one cycle when last count expires
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
        end else begin
            done <= !load && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
    assign busy = (count_reg != '0);
endmodule // rws_delay_counter

// ---- reset_wakeup_seq.sv ----
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rws_consts.svh"
// Function
// - Reset pin low in wait resets
// - IRQ falling edge exits wait, vectors
// - Break in emulation vectors to SWI
// - Watchdog timeout in wait resets
// - Clockgen, ADC, timebase wake vectors
// - Keypad request exits wait, vectors
// - Timer requests exit wait, vectors
// - Serial requests exit wait, vectors
// - CAN requests exit wait, vectors
// - Stop exits only on listed events
// - Timebase rollover wakes from stop
// - CAN activity wakes; data ignored
// - Stop recovery holds clocks 4096 cycles
// - Short recovery option gives 32 cycles
// - Timebase runs wait; stop if enabled
// - CAN active in wait, off in stop
// - Reset aborts, vectors, bus clock div4
// - External reset sets pin flag
// - Internal reset: pin 32, hold 32
// - Power-on: 4096 stab, flags set
// - Watchdog overflow resets; write clears
// - Low voltage: hold, 4096, flag
// - Source register read clears flags
module reset_wakeup_seq
    import rws_pkg::*;
#(
    parameter int STAB_CYCLES = `RWS_STAB_CYC,
    parameter int WDOG_CYCLES = `RWS_WDOG_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset pin, open drain
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe_n,
    // Reset and supply sources
    input wire logic lowVoltage,
    input wire logic illegalOpcode,
    input wire logic illegalAddress,
    input wire logic irqPin,
    input wire logic breakReq,
    // Wake requests: 0 clkgen 1 t1ch0 2 t1ch1 3 t1ovf 4 t2ch0 5 t2ch1 6 t2ovf
    // 7 spirx 8 spitx 9 scierr 10 scirx 11 scitx 12 keypad 13 adc
    // 14 timebase 15 canwake 16 canerr 17 canrx 18 cantx
    input wire logic [18:0] wakeReq,
    input wire logic canBusActivity,
    // Core side
    output logic coreReset,
    output logic coreClockEn,
    output logic moduleClockEn,
    output logic busClockEn,
    output logic vectorLoad,
    output logic [15:0] vectorAddr,
    output logic timebaseRun,
    output logic timebaseAccessOk,
    output logic canActive,
    output logic canAccessOk,
    output logic canRxEnable
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    initial begin
        if (STAB_CYCLES < 2 || STAB_CYCLES > 8191) $error("STAB_CYCLES out of range");
        if (WDOG_CYCLES < 2) $error("WDOG_CYCLES too small");
    end
    localparam int WD_W = $clog2(WDOG_CYCLES + 1);
    // ****************************************
    // State
    // ****************************************
    rws_mode_e mode_reg; // Current power mode
    rws_phase_e phase_reg; // Reset sequence phase
    logic [7:0] ctrl_reg; // Options and mode requests
    logic [7:0] source_reg; // Reset source flags
    logic [15:0] vector_reg; // Last vector issued
    logic [WD_W-1:0] wdog_reg; // Watchdog counter
    logic irqPrev_reg; // Previous irq level
    logic [1:0] busDiv_reg; // Bus clock divider
    logic porSeen_reg; // Power-on sequence pending
    logic lvPending_reg; // Low-voltage reset in progress
    logic canSync_reg; // CAN oscillator synchronised
    logic cntLoad; // Counter load strobe
    logic [12:0] cntValue; // Counter load value
    logic cntBusy; // Counter running
    logic cntDone; // Counter expired
    logic irqFall; // IRQ falling edge
    logic wdogTimeout; // Watchdog overflow
    logic internalRst; // Any internal reset source
    logic externalRst; // Pin driven low by others
    logic anyReset; // Reset in progress request
    logic wakeWait; // Event leaving wait
    logic wakeStop; // Event leaving stop
    logic wrEn; // APB write strobe
    logic rdEn; // APB read strobe
    logic [15:0] wakeVector; // Vector of winning request
    logic pinDriving; // Device pulls the pin low
    // ****************************************
    // Helper: priority vector of requests
    // ****************************************
    // Lowest index wins, matching the vector table order
    function automatic logic [15:0] pick_vector(input logic [18:0] req);
        logic [15:0] v;
        v = `RWS_VEC_TBASE;
        for (int i = 18; i >= 0; i--) begin
            if (req[i]) begin
                case (i)
                    0: v = `RWS_VEC_CLKGEN;
                    1: v = `RWS_VEC_T1CH0;
                    2: v = `RWS_VEC_T1CH1;
                    3: v = `RWS_VEC_T1OVF;
                    4: v = `RWS_VEC_T2CH0;
                    5: v = `RWS_VEC_T2CH1;
                    6: v = `RWS_VEC_T2OVF;
                    7: v = `RWS_VEC_SPIRX;
                    8: v = `RWS_VEC_SPITX;
                    9: v = `RWS_VEC_SCIERR;
                    10: v = `RWS_VEC_SCIRX;
                    11: v = `RWS_VEC_SCITX;
                    12: v = `RWS_VEC_KEYPAD;
                    13: v = `RWS_VEC_ADC;
                    14: v = `RWS_VEC_TBASE;
                    15: v = `RWS_VEC_CANWAKE;
                    16: v = `RWS_VEC_CANERR;
                    17: v = `RWS_VEC_CANRX;
                    default: v = `RWS_VEC_CANTX;
                endcase
            end
        end
        return v;
    endfunction
    // ****************************************
    // APB slave
    // ****************************************
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // Read data from flops; source read clears flags afterwards
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `RWS_ADDR_CTRL: prdata <= {24'h000000, ctrl_reg};
                `RWS_ADDR_STATUS: prdata <= {24'h000000, 1'b0, canSync_reg, cntBusy,
                    porSeen_reg, 1'b0, phase_reg};
                `RWS_ADDR_SOURCE: prdata <= {24'h000000, source_reg};
                `RWS_ADDR_VECTOR: prdata <= {16'h0000, vector_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
    // Control writes; mode request bits self clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `RWS_CTRL_RESET;
        end else if (anyReset) begin
            ctrl_reg <= `RWS_CTRL_RESET;
        end else if (wrEn && paddr == `RWS_ADDR_CTRL) begin
            ctrl_reg <= pwdata[7:0];
        end else begin
            ctrl_reg[`RWS_CTRL_WAITREQ] <= 1'b0;
            ctrl_reg[`RWS_CTRL_STOPREQ] <= 1'b0;
        end
    end
    // ****************************************
    // Event detection
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irqPrev_reg <= 1'b1;
        end else begin
            irqPrev_reg <= irqPin;
        end
    end
    assign irqFall = irqPrev_reg && !irqPin;
    assign pinDriving = (phase_reg == RWS_STAB) || (phase_reg == RWS_PINLOW);
    // Pin low while we are not driving it means an outside reset
    assign externalRst = !resetPinIn && !pinDriving;
    assign internalRst = wdogTimeout || illegalOpcode || illegalAddress || lowVoltage;
    assign anyReset = externalRst || internalRst;
    // ****************************************
    // Watchdog
    // ****************************************
    // Counter stops in stop mode; any write to the watchdog register clears it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdog_reg <= '0;
        end else if (phase_reg != RWS_IDLE || !ctrl_reg[`RWS_CTRL_WDOGEN]) begin
            wdog_reg <= '0;
        end else if (wrEn && paddr == `RWS_ADDR_WDOG) begin
            wdog_reg <= '0;
        end else if (mode_reg != RWS_STOP) begin
            wdog_reg <= wdog_reg + {{(WD_W-1){1'b0}}, 1'b1};
        end
    end
    assign wdogTimeout = (wdog_reg == WD_W'(WDOG_CYCLES - 1));
    // ****************************************
    // Reset sequence
    // ****************************************
    // Delay counter loads leaving IDLE for PINLOW or RECOVER, leaving STAB or PINLOW, and when STAB or HOLD finds it idle
    always_comb begin
        cntLoad = 1'b0;
        cntValue = 13'h0000;
        case (phase_reg)
            RWS_IDLE: begin
                if (mode_reg == RWS_STOP && (irqFall || wakeReq[12] || wakeReq[14]
                    || canBusActivity)) begin
                    cntLoad = 1'b1;
                    cntValue = ctrl_reg[`RWS_CTRL_SHORTREC] ? 13'(`RWS_SHORT_CYC - 1)
                        : 13'(STAB_CYCLES - 1);
                end else if (internalRst && !lowVoltage) begin
                    // Low voltage loads nothing here: a stale done would end STAB early
                    cntLoad = 1'b1;
                    cntValue = 13'(`RWS_PIN_CYC - 1);
                end
            end
            RWS_STAB: begin
                if (cntDone) begin
                    // Pin stays low 32 more after stabilisation
                    cntLoad = 1'b1;
                    cntValue = 13'(`RWS_PIN_CYC - 1);
                end else if (!cntBusy && !lowVoltage) begin
                    cntLoad = 1'b1;
                    cntValue = 13'(STAB_CYCLES - 1);
                end
            end
            default: begin
                if (cntDone && phase_reg == RWS_PINLOW) begin
                    cntLoad = 1'b1;
                    cntValue = 13'(`RWS_CORE_CYC - 1);
                end else if (phase_reg == RWS_HOLD
                    && (!resetPinIn || (!cntBusy && !cntDone))) begin
                    // Hold restarts while an outside party keeps the pin low
                    cntLoad = 1'b1;
                    cntValue = 13'(`RWS_CORE_CYC - 1);
                end
            end
        endcase
    end
    rws_delay_counter #(.WIDTH(13)) u_delay (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(cntLoad),
        .loadValue(cntValue),
        .busy(cntBusy),
        .done(cntDone)
    );
    // Phase machine
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= RWS_STAB;
            lvPending_reg <= 1'b0;
        end else begin
            case (phase_reg)
                RWS_IDLE: begin
                    if (cntLoad && mode_reg == RWS_STOP && !internalRst) begin
                        phase_reg <= RWS_RECOVER;
                    end else if (lowVoltage) begin
                        phase_reg <= RWS_STAB;
                        lvPending_reg <= 1'b1;
                    end else if (internalRst) begin
                        phase_reg <= RWS_PINLOW;
                    end else if (externalRst) begin
                        phase_reg <= RWS_HOLD;
                    end
                end
                RWS_STAB: begin
                    if (cntDone) begin
                        phase_reg <= RWS_PINLOW;
                    end
                end
                RWS_PINLOW: begin
                    if (cntDone) begin
                        phase_reg <= RWS_HOLD;
                    end
                end
                RWS_HOLD: begin
                    if (cntDone) begin
                        phase_reg <= RWS_IDLE;
                        lvPending_reg <= 1'b0;
                    end
                end
                RWS_RECOVER: begin
                    if (cntDone) begin
                        phase_reg <= RWS_IDLE;
                    end
                end
                default: phase_reg <= RWS_IDLE;
            endcase
        end
    end
    // ****************************************
    // Power mode and vectoring
    // ****************************************
    // wait exit
    assign wakeWait = irqFall || (breakReq && ctrl_reg[`RWS_CTRL_EMUL]) || (wakeReq != '0);
    assign wakeStop = irqFall || wakeReq[12] || wakeReq[14] || canBusActivity;
    assign wakeVector = irqFall ? `RWS_VEC_IRQ
        : (breakReq && ctrl_reg[`RWS_CTRL_EMUL]) ? `RWS_VEC_SWI : pick_vector(wakeReq);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= RWS_RUN;
            vector_reg <= `RWS_VEC_RESET;
            vectorLoad <= 1'b0;
        end else begin
            vectorLoad <= 1'b0;
            if (phase_reg == RWS_HOLD && cntDone) begin
                mode_reg <= RWS_RUN;
                vector_reg <= `RWS_VEC_RESET;
                vectorLoad <= 1'b1;
            end else if (phase_reg == RWS_RECOVER && cntDone) begin
                mode_reg <= RWS_RUN;
                vectorLoad <= 1'b1;
            end else if (phase_reg == RWS_IDLE && mode_reg == RWS_STOP && wakeStop) begin
                vector_reg <= irqFall ? `RWS_VEC_IRQ : wakeReq[12] ? `RWS_VEC_KEYPAD
                    : wakeReq[14] ? `RWS_VEC_TBASE : `RWS_VEC_CANWAKE;
            end else if (phase_reg == RWS_IDLE && mode_reg == RWS_WAIT && wakeWait) begin
                mode_reg <= RWS_RUN;
                vector_reg <= wakeVector;
                vectorLoad <= 1'b1;
            end else if (phase_reg == RWS_IDLE && mode_reg == RWS_RUN) begin
                if (ctrl_reg[`RWS_CTRL_STOPREQ]) begin
                    mode_reg <= RWS_STOP;
                end else if (ctrl_reg[`RWS_CTRL_WAITREQ]) begin
                    mode_reg <= RWS_WAIT;
                end
            end
        end
    end
    // Reset flags accumulate until read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            source_reg <= `RWS_SRC_RESET;
            porSeen_reg <= 1'b1;
        end else begin
            if (rdEn && paddr == `RWS_ADDR_SOURCE) begin
                source_reg <= 8'h00;
            end
            if (porSeen_reg && phase_reg == RWS_HOLD) begin
                source_reg <= 8'h00 | (8'h01 << `RWS_SRC_POR) | (8'h01 << `RWS_SRC_LVR);
                porSeen_reg <= 1'b0;
            end else if (phase_reg == RWS_IDLE) begin
                if (lowVoltage) source_reg[`RWS_SRC_LVR] <= 1'b1;
                if (wdogTimeout) source_reg[`RWS_SRC_WDOG] <= 1'b1;
                if (illegalOpcode) source_reg[`RWS_SRC_ILOP] <= 1'b1;
                if (illegalAddress) source_reg[`RWS_SRC_ILAD] <= 1'b1;
                if (externalRst && !internalRst) source_reg[`RWS_SRC_PIN] <= 1'b1;
            end
        end
    end
    // CAN synchronised once clocks run again
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            canSync_reg <= 1'b0;
        end else begin
            canSync_reg <= (mode_reg != RWS_STOP) && (phase_reg == RWS_IDLE);
        end
    end
    // bus clock is crystal divided by four
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busDiv_reg <= 2'h0;
        end else if (phase_reg != RWS_IDLE) begin
            busDiv_reg <= 2'h0;
        end else begin
            busDiv_reg <= busDiv_reg + 2'h1;
        end
    end
    // ****************************************
    // Outputs
    // ****************************************
    // device pulls pin low
    assign resetPinOut = 1'b0;
    assign resetPinOe_n = !pinDriving;
    assign coreReset = (phase_reg != RWS_IDLE && phase_reg != RWS_RECOVER) || anyReset;
    assign coreClockEn = (phase_reg == RWS_IDLE) && (mode_reg == RWS_RUN) && !anyReset;
    assign moduleClockEn = (phase_reg == RWS_IDLE) && (mode_reg != RWS_STOP) && !anyReset;
    assign busClockEn = moduleClockEn && (busDiv_reg == 2'(`RWS_XTAL_DIV - 1));
    // timebase in wait; stop if oscillator runs
    assign timebaseRun = (mode_reg != RWS_STOP) || ctrl_reg[`RWS_CTRL_OSCSTOP];
    assign timebaseAccessOk = (mode_reg == RWS_RUN);
    assign canActive = (mode_reg != RWS_STOP);
    assign canAccessOk = (mode_reg == RWS_RUN);
    assign canRxEnable = canSync_reg;
    assign vectorAddr = vector_reg;
endmodule // reset_wakeup_seq

// ---- rws_sva.sv ----
`timescale 1ns/1ps
// ****************************
// Sequencer port checker
// ****************************
module rws_sva
    import rws_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic resetPinOut,
    input wire logic resetPinOe_n,
    input wire logic coreReset,
    input wire logic coreClockEn,
    input wire logic moduleClockEn,
    input wire logic busClockEn,
    input wire logic vectorLoad,
    input wire logic [15:0] vectorAddr,
    input wire logic timebaseAccessOk,
    input wire logic canActive,
    input wire logic canAccessOk
);
    // One clock domain, so one default for all checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    pin_means_reset_a: assert property (!resetPinOe_n |-> coreReset)
        else $error("core left reset while pin pulled");
    reset_tail_a: assert property ($rose(resetPinOe_n) |-> coreReset [*8])
        else $error("reset ended with pin release");
    clocks_off_a: assert property (coreReset |-> !coreClockEn && !moduleClockEn)
        else $error("clock ran during reset");
    reset_vector_a: assert property ($fell(coreReset) |-> ##[0:2]
        (vectorLoad && vectorAddr == 16'hFFFE)) else $error("no reset vector");
    open_drain_a: assert property (resetPinOut == 1'b0)
        else $error("reset pin driven high");
    bus_div_a: assert property (busClockEn |=> !busClockEn [*3])
        else $error("bus clock faster than quarter");
    can_access_a: assert property (canAccessOk |-> canActive)
        else $error("can access while inactive");
    sleep_access_a: assert property (!coreClockEn && !coreReset
        |-> !timebaseAccessOk && !canAccessOk) else $error("access while asleep");
    vector_pair_a: assert property (vectorLoad |-> vectorAddr[0] == 1'b0
        && vectorAddr[15:8] == 8'hFF) else $error("vector not a pair high byte");
endmodule // rws_sva
bind reset_wakeup_seq rws_sva chk_u (.sys_clk, .nrst, .resetPinOut, .resetPinOe_n,
    .coreReset, .coreClockEn, .moduleClockEn, .busClockEn, .vectorLoad, .vectorAddr,
    .timebaseAccessOk, .canActive, .canAccessOk);

// ---- rws_periph_model.sv ----
`timescale 1ns/1ps
// ****************************
// Peripheral request model
// ****************************
module rws_periph_model
    import rws_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [18:0] reqSet,
    input wire logic vectorLoad,
    output logic [18:0] wakeReq
);
    // Flags stay up until the core vectors, as real peripheral flags do
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wakeReq <= 19'h00000;
        end else begin
            wakeReq <= (vectorLoad ? 19'h00000 : wakeReq) | reqSet;
        end
    end
endmodule // rws_periph_model

// ---- testbench.sv ----
`timescale 1ns/1ps
// ****************************
// Sequencer testbench
// ****************************
module testbench
    import rws_pkg::*;
;
    logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, resetPinOut, resetPinOe_n, resetPinIn, extLow = 1'b0;
    logic lowVoltage = 1'b0, irqPin = 1'b1, breakReq = 1'b0, coreReset, coreClockEn;
    logic vectorLoad, timebaseRun, timebaseAccessOk, canActive, canAccessOk;
    logic [18:0] reqSet = 19'h00000, wakeReq;
    logic [15:0] vectorAddr;
    int bad_count = 0, checks = 0;
    // Wake vectors in request index order
    localparam logic [15:0] VEC [19] = '{16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0,
        16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0,
        16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4};
    // Open-drain reset wire with pull-up
    assign resetPinIn = !(extLow || (!resetPinOe_n && !resetPinOut));
    reset_wakeup_seq #(.STAB_CYCLES(40), .WDOG_CYCLES(200)) dut_u (.sys_clk, .nrst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .resetPinIn,
        .resetPinOut, .resetPinOe_n, .lowVoltage, .illegalOpcode(1'b0),
        .illegalAddress(1'b0), .irqPin, .breakReq, .wakeReq, .canBusActivity(1'b0),
        .coreReset, .coreClockEn, .moduleClockEn(), .busClockEn(), .vectorLoad,
        .vectorAddr, .timebaseRun, .timebaseAccessOk, .canActive, .canAccessOk,
        .canRxEnable());
    rws_periph_model src_u (.sys_clk, .nrst, .reqSet, .vectorLoad, .wakeReq);
    always #12.5 sys_clk = ~sys_clk;
    task automatic close_out();
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Counts within two cycles of the figure, as sampling alignment may shift one
    task automatic near(input int g, input int e);
        cmp(g >= e - 2 && g <= e + 2, 1);
    endtask
    // APB transfer; an idle edge after it keeps psel from toggling twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd_cmp(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h00000000, q);
        cmp(q, e);
    endtask
    task automatic wait_vec(input int lim, output int n, output logic [15:0] v);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (vectorLoad !== 1'b1 && n < lim);
        v = vectorAddr;
    endtask
    task automatic pin_low(output int n);
        n = 0;
        while (resetPinOe_n !== 1'b1 && n < 500) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    task automatic pulse(input logic [18:0] m);
        reqSet <= m;
        @(posedge sys_clk);
        reqSet <= 19'h00000;
    endtask
    task automatic t_reset(input logic [31:0] src);
        int n;
        logic [15:0] v;
        pin_low(n);
        near(n, 72);
        wait_vec(100, n, v);
        cmp(v, 16'hFFFE);
        near(n, 32);
        rd_cmp(12'h008, src);
        rd_cmp(12'h008, 32'h00000000);
    endtask
    task automatic t_wake();
        int n;
        logic [15:0] v;
        for (int i = 0; i < 19; i++) begin
            wr(12'h000, 32'h00000010);
            @(posedge sys_clk);
            cmp({timebaseRun, timebaseAccessOk, canActive, canAccessOk}, 4'hA);
            pulse(19'h00001 << i);
            wait_vec(20, n, v);
            cmp(v, VEC[i]);
        end
        wr(12'h000, 32'h00000010);
        irqPin <= 1'b0;
        wait_vec(20, n, v);
        irqPin <= 1'b1;
        cmp(v, 16'hFFFA);
        wr(12'h000, 32'h00000018);
        breakReq <= 1'b1;
        wait_vec(20, n, v);
        breakReq <= 1'b0;
        cmp(v, 16'hFFFC);
        wr(12'h000, 32'h00000010);
        extLow <= 1'b1;
        repeat (4) @(posedge sys_clk);
        extLow <= 1'b0;
        wait_vec(200, n, v);
        cmp(v, 16'hFFFE);
        rd_cmp(12'h008, 32'h00000040);
    endtask
    task automatic t_stop();
        int n;
        logic [15:0] v;
        wr(12'h000, 32'h00000021);
        @(posedge sys_clk);
        cmp({timebaseRun, timebaseAccessOk, canActive, canAccessOk}, 4'h0);
        pulse(19'h00008);
        wait_vec(60, n, v);
        cmp(n, 60);
        pulse(19'h01000);
        wait_vec(100, n, v);
        cmp(v, 16'hFFE0);
        near(n, 32);
        wr(12'h000, 32'h00000022);
        @(posedge sys_clk);
        cmp({timebaseRun, timebaseAccessOk}, 2'b10);
        pulse(19'h04000);
        wait_vec(100, n, v);
        cmp(v, 16'hFFDC);
        near(n, 40);
    endtask
    task automatic t_wdog();
        int n;
        logic [15:0] v;
        wr(12'h000, 32'h00000014);
        repeat (3) begin
            repeat (150) @(posedge sys_clk);
            wr(12'h010, 32'h0000005A);
        end
        cmp(coreReset, 1'b0);
        wait_vec(400, n, v);
        cmp(v, 16'hFFFE);
        rd_cmp(12'h008, 32'h00000010);
        lowVoltage <= 1'b1;
        repeat (20) @(posedge sys_clk);
        cmp({resetPinOe_n, coreReset}, 2'b01);
        lowVoltage <= 1'b0;
        t_reset(32'h00000002);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset(32'h00000082);
        t_wake();
        t_stop();
        t_wdog();
        close_out();
    end
    // Watchdog: whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        close_out();
    end
endmodule // testbench
